// ===== hdl/memmap_pkg.sv
// Shared constants, carriers and decode helpers for the memory map block.
// Assumes a single core clock; all users refer to items as memmap_pkg::name.
package memmap_pkg;

   // ----------------------------------------
   // Program side
   // ----------------------------------------
   localparam int           PC_W        = 13;
   localparam int           PWORD_W     = 14;
   localparam int           PROG_AW     = 12;
   localparam logic [12:0]  RESET_VEC   = 13'h0000;
   localparam logic [12:0]  IRQ_VEC     = 13'h0004;

   // ----------------------------------------
   // Data side
   // ----------------------------------------
   localparam int           DADDR_W     = 9;
   localparam int           OFS_W       = 7;
   localparam int           BANK_W      = 2;
   localparam int           BANK_HI_BIT = 6;
   localparam int           BANK_LO_BIT = 5;
   localparam int           IPAGE_BIT   = 7;
   localparam logic [6:0]   OFS_INDIRECT = 7'h00;
   localparam logic [6:0]   OFS_STATUS  = 7'h03;
   localparam logic [6:0]   OFS_POINTER = 7'h04;
   localparam logic [6:0]   OFS_GPR_LO  = 7'h20;
   localparam logic [6:0]   OFS_COMMON  = 7'h70;
   localparam logic [7:0]   STATUS_RST  = 8'h18;
   localparam logic [7:0]   POINTER_RST = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic              irq_take;
      logic              load;
      logic              inc;
      logic [PC_W-1:0]   target;
   } pc_ctl_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [OFS_W-1:0]  offset;
      logic [7:0]        wdata;
   } data_req_t;

   typedef struct packed {
      logic              sel;
      logic              write;
      logic [DADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } sfr_req_t;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic is_gpr(input logic [OFS_W-1:0] ofs);
      return ofs >= OFS_GPR_LO;
   endfunction : is_gpr

   function automatic logic is_common(input logic [OFS_W-1:0] ofs);
      return ofs >= OFS_COMMON;
   endfunction : is_common

   function automatic logic is_local_sfr(input logic [OFS_W-1:0] ofs);
      return (ofs == OFS_STATUS) || (ofs == OFS_POINTER);
   endfunction : is_local_sfr

endpackage : memmap_pkg

// ===== hdl/prog_store.sv
// Program word store with a registered read port and a load port.
// Assumes the load port and the fetch port share the core clock.
`timescale 1ns/1ns
module prog_store #(
   parameter int AW = 12,
   parameter int DW = 14
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata_r
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ----------------------------------------
   // Write and registered read
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      if (re)
      begin
         rdata_r <= mem[raddr];
      end
   end

endmodule : prog_store

// ===== hdl/gpr_ram.sv
// General purpose byte store with a registered read port.
// Assumes one access per cycle from the data path decoder.
`timescale 1ns/1ns
module gpr_ram #(
   parameter int AW = 9
) (
   input  wire logic          clk_sys,
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata_r
);

   logic [7:0] mem [0:(1<<AW)-1];

   // ----------------------------------------
   // Single port, read data held over writes
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (en)
      begin
         if (we)
         begin
            mem[addr] <= wdata;
         end
         else
         begin
            rdata_r <= mem[addr];
         end
      end
   end

endmodule : gpr_ram

// ===== hdl/memory_map_address_decode.sv
// Program counter, program fetch path and banked data address decode.
// Assumes the core drives pc_ctl and data_req synchronously on clk_sys.
`timescale 1ns/1ns
module memory_map_address_decode #(
   parameter int PROG_AW = memmap_pkg::PROG_AW,
   parameter int RAM_AW  = memmap_pkg::DADDR_W
) (
   input  wire logic                             clk_sys,
   input  wire logic                             resetn,
   input  wire memmap_pkg::pc_ctl_t              pc_ctl,
   input  wire logic                             fetch_en,
   output logic      [memmap_pkg::PC_W-1:0]      pc,
   output logic      [memmap_pkg::PWORD_W-1:0]   fetch_word,
   output logic                                  fetch_valid,
   input  wire logic                             prog_we,
   input  wire logic [PROG_AW-1:0]               prog_waddr,
   input  wire logic [memmap_pkg::PWORD_W-1:0]   prog_wdata,
   input  wire memmap_pkg::data_req_t            data_req,
   output logic      [7:0]                       data_rdata,
   output logic                                  data_rvalid,
   output memmap_pkg::sfr_req_t                  sfr_req,
   input  wire logic [7:0]                       sfr_rdata,
   output logic      [memmap_pkg::BANK_W-1:0]    bank_sel,
   output logic      [7:0]                       indirect_pointer_register
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // Program counter
   // ----------------------------------------
   logic [memmap_pkg::PC_W-1:0] pc_r;
   logic [memmap_pkg::PC_W-1:0] pc_nxt;
   logic                        fvalid_r;
   logic                        fvalid_nxt;

   always_comb
   begin
      pc_nxt     = pc_r;
      fvalid_nxt = fetch_en;
      if (pc_ctl.irq_take)
      begin
         pc_nxt = memmap_pkg::IRQ_VEC;
      end
      else if (pc_ctl.load)
      begin
         pc_nxt = pc_ctl.target;
      end
      else if (pc_ctl.inc)
      begin
         pc_nxt = pc_r + 13'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         pc_r     <= memmap_pkg::RESET_VEC;
         fvalid_r <= 1'b0;
      end
      else
      begin
         pc_r     <= pc_nxt;
         fvalid_r <= fvalid_nxt;
      end
   end

   assign pc          = pc_r;
   assign fetch_valid = fvalid_r;

   // ----------------------------------------
   // Program fetch port
   // ----------------------------------------
   logic [PROG_AW-1:0] fetch_addr;

   assign fetch_addr = pc_r[PROG_AW-1:0];

   prog_store #(
      .AW (PROG_AW),
      .DW (memmap_pkg::PWORD_W)
   ) u_prog (
      .clk_sys (clk_sys),
      .we      (prog_we),
      .waddr   (prog_waddr),
      .wdata   (prog_wdata),
      .re      (fetch_en),
      .raddr   (fetch_addr),
      .rdata_r (fetch_word)
   );

   // ----------------------------------------
   // Mirrored special registers
   // ----------------------------------------
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] ptr_r;
   logic [7:0] ptr_nxt;

   // ----------------------------------------
   // Data address formation
   // ----------------------------------------
   logic [memmap_pkg::BANK_W-1:0]  bank;
   logic                           indirect;
   logic [memmap_pkg::DADDR_W-1:0] eff_addr;
   logic [memmap_pkg::OFS_W-1:0]   eff_ofs;
   logic                           hit_gpr;
   logic                           hit_local;
   logic [RAM_AW-1:0]              ram_addr;

   assign bank     = status_r[memmap_pkg::BANK_HI_BIT:memmap_pkg::BANK_LO_BIT];
   assign indirect = data_req.offset == memmap_pkg::OFS_INDIRECT;

   always_comb
   begin
      if (indirect)
      begin
         eff_addr = {status_r[memmap_pkg::IPAGE_BIT], ptr_r};
      end
      else
      begin
         eff_addr = {bank, data_req.offset};
      end
   end

   assign eff_ofs   = eff_addr[memmap_pkg::OFS_W-1:0];
   assign hit_gpr   = memmap_pkg::is_gpr(eff_ofs);
   assign hit_local = memmap_pkg::is_local_sfr(eff_ofs);

   always_comb
   begin
      if (memmap_pkg::is_common(eff_ofs))
      begin
         ram_addr = RAM_AW'({2'b00, eff_ofs});
      end
      else
      begin
         ram_addr = RAM_AW'(eff_addr);
      end
   end

   // ----------------------------------------
   // Special register writes
   // ----------------------------------------
   logic wr_ok;

   assign wr_ok = data_req.valid && data_req.write && !(indirect && ptr_r == 8'h00);

   always_comb
   begin
      status_nxt = status_r;
      ptr_nxt    = ptr_r;
      if (wr_ok && eff_ofs == memmap_pkg::OFS_STATUS)
      begin
         status_nxt = data_req.wdata;
      end
      if (wr_ok && eff_ofs == memmap_pkg::OFS_POINTER)
      begin
         ptr_nxt = data_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         status_r <= memmap_pkg::STATUS_RST;
         ptr_r    <= memmap_pkg::POINTER_RST;
      end
      else
      begin
         status_r <= status_nxt;
         ptr_r    <= ptr_nxt;
      end
   end

   assign bank_sel                  = bank;
   assign indirect_pointer_register = ptr_r;

   // ----------------------------------------
   // Region steering
   // ----------------------------------------
   logic ram_en;
   logic [7:0] ram_rdata;

   assign ram_en = data_req.valid && hit_gpr;

   always_comb
   begin
      sfr_req.sel   = data_req.valid && !hit_gpr && !hit_local
                      && eff_ofs != memmap_pkg::OFS_INDIRECT;
      sfr_req.write = data_req.write;
      sfr_req.addr  = eff_addr;
      sfr_req.wdata = data_req.wdata;
   end

   gpr_ram #(
      .AW (RAM_AW)
   ) u_gpr (
      .clk_sys (clk_sys),
      .en      (ram_en),
      .we      (wr_ok),
      .addr    (ram_addr),
      .wdata   (data_req.wdata),
      .rdata_r (ram_rdata)
   );

   // ----------------------------------------
   // Read return
   // ----------------------------------------
   logic       rvalid_r;
   logic       rvalid_nxt;
   logic       from_ram_r;
   logic       from_ram_nxt;
   logic [7:0] hold_r;
   logic [7:0] hold_nxt;

   always_comb
   begin
      rvalid_nxt   = data_req.valid && !data_req.write;
      from_ram_nxt = from_ram_r;
      hold_nxt     = hold_r;
      if (data_req.valid && !data_req.write)
      begin
         from_ram_nxt = hit_gpr;
         if (eff_ofs == memmap_pkg::OFS_STATUS)
         begin
            hold_nxt = status_r;
         end
         else if (eff_ofs == memmap_pkg::OFS_POINTER)
         begin
            hold_nxt = ptr_r;
         end
         else if (eff_ofs == memmap_pkg::OFS_INDIRECT)
         begin
            hold_nxt = 8'h00;
         end
         else
         begin
            hold_nxt = sfr_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rvalid_r   <= 1'b0;
         from_ram_r <= 1'b0;
         hold_r     <= 8'h00;
      end
      else
      begin
         rvalid_r   <= rvalid_nxt;
         from_ram_r <= from_ram_nxt;
         hold_r     <= hold_nxt;
      end
   end

   assign data_rvalid = rvalid_r;
   assign data_rdata  = from_ram_r ? ram_rdata : hold_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_reset_vec;
      @(posedge clk_sys) disable iff (!resetn)
      !rst_n_r |=> pc_r == 13'h0000;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

   property p_irq_vec;
      @(posedge clk_sys) disable iff (!rst_n_r)
      pc_ctl.irq_take |=> pc_r == 13'h0004;
   endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("pc not at interrupt vector");

   property p_pc_inc;
      @(posedge clk_sys) disable iff (!rst_n_r)
      pc_ctl.inc && !pc_ctl.load && !pc_ctl.irq_take |=> pc_r == 13'($past(pc_r) + 13'h0001);
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not step by one");

   property p_wrap;
      @(posedge clk_sys) disable iff (!rst_n_r)
      fetch_en && pc_r[12] |-> fetch_addr == pc_r[11:0] && fetch_addr != pc_r;
   endproperty
   a_wrap: assert property (p_wrap) else $error("fetch address did not wrap");

   property p_concurrent;
      @(posedge clk_sys) disable iff (!rst_n_r)
      fetch_en && data_req.valid && !data_req.write |=> fetch_valid && data_rvalid;
   endproperty
   a_concurrent: assert property (p_concurrent) else $error("fetch and data did not overlap");

   property p_direct;
      @(posedge clk_sys) disable iff (!rst_n_r)
      data_req.valid && !indirect |-> eff_addr == {status_r[6:5], data_req.offset};
   endproperty
   a_direct: assert property (p_direct) else $error("direct address wrong");

   property p_indirect;
      @(posedge clk_sys) disable iff (!rst_n_r)
      data_req.valid && indirect |-> eff_addr[7:0] == ptr_r;
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect address wrong");

   property p_region;
      @(posedge clk_sys) disable iff (!rst_n_r)
      data_req.valid |-> (eff_ofs >= 7'h20) == ram_en && !(ram_en && sfr_req.sel);
   endproperty
   a_region: assert property (p_region) else $error("region decode wrong");

   property p_mirror;
      @(posedge clk_sys) disable iff (!rst_n_r)
      data_req.valid && data_req.write && !indirect && data_req.offset == 7'h03
      |=> bank_sel == $past(data_req.wdata[6:5]);
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirrored status write lost");

endmodule : memory_map_address_decode

// ===== test/sfr_model.sv
// Stub of the special registers that sit outside the decode block.
// Assumes sfr_req is combinational and writes land on the core clock.
`timescale 1ns/1ns
module sfr_model (
   input  wire logic                 clk_sys,
   input  wire memmap_pkg::sfr_req_t sfr_req,
   output logic      [7:0]           sfr_rdata
);
   // ----------------------------------------
   // Storage and read path
   // ----------------------------------------
   logic [7:0] mem_r [0:511];
   logic [7:0] last_r;
   logic [7:0] last_nxt;

   always_comb
   begin
      if (sfr_req.sel && !sfr_req.write)
      begin
         sfr_rdata = mem_r[sfr_req.addr];
      end
      else
      begin
         sfr_rdata = ~last_r;
      end
      last_nxt = sfr_rdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sfr_req.sel && sfr_req.write)
      begin
         mem_r[sfr_req.addr] <= sfr_req.wdata;
      end
      last_r <= last_nxt;
   end
endmodule : sfr_model

// ===== test/memory_map_address_decode_tb.sv
// Self-checking bench for the program counter, fetch and data decode.
// Assumes sfr_model answers the external special register port.
`timescale 1ns/1ns
module memory_map_address_decode_tb;
   logic                   clk_sys;
   logic                   resetn;
   memmap_pkg::pc_ctl_t    pc_ctl;
   logic                   fetch_en;
   logic [12:0]            pc;
   logic [13:0]            fetch_word;
   logic                   fetch_valid;
   logic                   prog_we;
   logic [11:0]            prog_waddr;
   logic [13:0]            prog_wdata;
   memmap_pkg::data_req_t  data_req;
   logic [7:0]             data_rdata;
   logic                   data_rvalid;
   memmap_pkg::sfr_req_t   sfr_req;
   logic [7:0]             sfr_rdata;
   logic [1:0]             bank_sel;
   logic [7:0]             indirect_pointer_register;
   int                     miscompares;
   int                     num_checks;
   int                     cycles;
   logic [7:0]             rd;
   logic [13:0]            wd;
   memmap_pkg::sfr_req_t   seen;

   memory_map_address_decode u_dut (.clk_sys(clk_sys), .resetn(resetn), .pc_ctl(pc_ctl),
      .fetch_en(fetch_en), .pc(pc), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
      .prog_we(prog_we), .prog_waddr(prog_waddr), .prog_wdata(prog_wdata),
      .data_req(data_req), .data_rdata(data_rdata), .data_rvalid(data_rvalid),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .bank_sel(bank_sel),
      .indirect_pointer_register(indirect_pointer_register));
   sfr_model u_sfr (.clk_sys(clk_sys), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

   // ----------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         miscompares = miscompares + 1;
         wrap_up();
      end
   end

   task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // ----------------------------------------
   // Port tasks
   // ----------------------------------------
   task automatic do_reset();
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check_val("pc in reset", 16'h0000, {3'h0, pc});
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask : do_reset

   task automatic pc_op(input logic irq, input logic ld, input logic inc, input logic [12:0] t);
      @(posedge clk_sys);
      pc_ctl <= '{irq_take: irq, load: ld, inc: inc, target: t};
      @(posedge clk_sys);
      pc_ctl <= '0;
      #1;
   endtask : pc_op

   task automatic prog_wr(input logic [11:0] a, input logic [13:0] d);
      @(posedge clk_sys);
      prog_we    <= 1'b1;
      prog_waddr <= a;
      prog_wdata <= d;
      @(posedge clk_sys);
      prog_we    <= 1'b0;
   endtask : prog_wr

   task automatic fetch(output logic [13:0] w);
      @(posedge clk_sys);
      fetch_en <= 1'b1;
      @(posedge clk_sys);
      fetch_en <= 1'b0;
      #1;
      check_val("fetch_valid", 16'h0001, {15'h0, fetch_valid});
      w = fetch_word;
   endtask : fetch

   task automatic dacc(input logic wr, input logic [6:0] ofs, input logic [7:0] d);
      @(posedge clk_sys);
      data_req <= '{valid: 1'b1, write: wr, offset: ofs, wdata: d};
      #1;
      seen = sfr_req;
      @(posedge clk_sys);
      data_req.valid <= 1'b0;
      #1;
      if (!wr)
      begin
         check_val("data_rvalid", 16'h0001, {15'h0, data_rvalid});
         rd = data_rdata;
      end
   endtask : dacc

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_program();
      prog_wr(12'h123, 14'h2ABC);
      prog_wr(12'hFFF, 14'h1555);
      prog_wr(12'h000, 14'h3A5A);
      pc_op(1'b0, 1'b1, 1'b0, 13'h1123);
      check_val("pc load", 16'h1123, {3'h0, pc});
      fetch(wd);
      check_val("wrapped word", 16'h2ABC, {2'h0, wd});
      pc_op(1'b0, 1'b1, 1'b0, 13'h0FFF);
      fetch(wd);
      check_val("top word", 16'h1555, {2'h0, wd});
      pc_op(1'b0, 1'b0, 1'b1, 13'h0000);
      check_val("pc inc", 16'h1000, {3'h0, pc});
      fetch(wd);
      check_val("wrap word", 16'h3A5A, {2'h0, wd});
      pc_op(1'b1, 1'b1, 1'b1, 13'h0777);
      check_val("pc irq", 16'h0004, {3'h0, pc});
      do_reset();
      check_val("pc after reset", 16'h0000, {3'h0, pc});
   endtask : sc_program

   task automatic sc_banks();
      for (int b = 0; b < 4; b++)
      begin
         dacc(1'b1, 7'h03, {1'b0, 2'(b), 5'h18});
         check_val("bank_sel", 16'(b), {14'h0, bank_sel});
         dacc(1'b0, 7'h03, 8'h00);
         check_val("status mirror", {8'h0, 1'b0, 2'(b), 5'h18}, {8'h0, rd});
         dacc(1'b1, 7'h30, 8'hC0 + 8'(b));
         check_val("gpr sel", 16'h0000, {15'h0, seen.sel});
         dacc(1'b1, 7'h1F, 8'h50 + 8'(b));
         check_val("sfr addr", {7'h0, 2'(b), 7'h1F}, {7'h0, seen.addr});
         check_val("sfr sel", 16'h0001, {15'h0, seen.sel});
      end
      dacc(1'b1, 7'h7F, 8'h77);
      for (int b = 0; b < 4; b++)
      begin
         dacc(1'b1, 7'h03, {1'b0, 2'(b), 5'h18});
         dacc(1'b0, 7'h30, 8'h00);
         check_val("gpr per bank", 16'h00C0 + 16'(b), {8'h0, rd});
         dacc(1'b0, 7'h1F, 8'h00);
         check_val("sfr readback", 16'h0050 + 16'(b), {8'h0, rd});
         dacc(1'b0, 7'h7F, 8'h00);
         check_val("top offset", 16'h0077, {8'h0, rd});
      end
   endtask : sc_banks

   task automatic sc_indirect();
      dacc(1'b1, 7'h03, 8'h18);
      dacc(1'b1, 7'h04, 8'h35);
      check_val("pointer", 16'h0035, {8'h0, indirect_pointer_register});
      dacc(1'b1, 7'h00, 8'hA5);
      dacc(1'b0, 7'h35, 8'h00);
      check_val("indirect write", 16'h00A5, {8'h0, rd});
      dacc(1'b1, 7'h04, 8'hB0);
      check_val("read data stands", 16'h00A5, {8'h0, data_rdata});
      dacc(1'b0, 7'h00, 8'h00);
      check_val("indirect bank1", 16'h00C1, {8'h0, rd});
      dacc(1'b1, 7'h03, 8'h98);
      dacc(1'b1, 7'h04, 8'h30);
      dacc(1'b0, 7'h00, 8'h00);
      check_val("indirect page", 16'h00C2, {8'h0, rd});
      dacc(1'b1, 7'h04, 8'h00);
      dacc(1'b0, 7'h00, 8'h00);
      check_val("null pointer", 16'h0000, {8'h0, rd});
   endtask : sc_indirect

   task automatic sc_concurrent();
      pc_op(1'b0, 1'b1, 1'b0, 13'h0123);
      @(posedge clk_sys);
      fetch_en <= 1'b1;
      data_req <= '{valid: 1'b1, write: 1'b0, offset: 7'h35, wdata: 8'h00};
      @(posedge clk_sys);
      fetch_en       <= 1'b0;
      data_req.valid <= 1'b0;
      #1;
      check_val("both valid", 16'h0003, {14'h0, fetch_valid, data_rvalid});
      check_val("both data", {2'h0, 14'h2ABC}, {2'h0, fetch_word});
      check_val("both byte", 16'h00A5, {8'h0, data_rdata});
   endtask : sc_concurrent

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      miscompares = 0;
      num_checks  = 0;
      cycles      = 0;
      resetn      = 1'b0;
      pc_ctl      = '0;
      fetch_en    = 1'b0;
      prog_we     = 1'b0;
      prog_waddr  = 12'h000;
      prog_wdata  = 14'h0000;
      data_req    = '0;
      do_reset();
      check_val("bank reset", 16'h0000, {14'h0, bank_sel});
      check_val("pointer reset", 16'h0000, {8'h0, indirect_pointer_register});
      sc_program();
      sc_banks();
      sc_indirect();
      sc_concurrent();
      wrap_up();
   end
endmodule : memory_map_address_decode_tb
